// ### shared/qfb_consts.svh
`ifndef QFB_CONSTS_SVH
`define QFB_CONSTS_SVH

// ==========================================
// queue geometry
`define QFB_NQ        4
`define QFB_QA_W      2
`define QFB_CNT_W     19
`define QFB_VAL_W     16
`define QFB_UNIT_W    3
`define QFB_UNIT_36   3'h4
`define QFB_UNIT_18   3'h2
`define QFB_UNIT_9    3'h1

// ==========================================
// reset values
`define QFB_OFF_LO    16'h0008
`define QFB_OFF_HI    16'h0080
`define QFB_DEPTH_RST 16'h1000

// ==========================================
// register byte offsets, and the upper address nibble of the offset and count arrays
`define QFB_A_CTRL    8'h00
`define QFB_A_FLAGS   8'h04
`define QFB_A_ISTS    8'h08
`define QFB_A_IMASK   8'h0C
`define QFB_A_DEPTH   8'h10
`define QFB_A_OFF_HI  4'h2
`define QFB_A_CNT_HI  4'h3

// ==========================================
// interrupt status bit positions
`define QFB_IRQ_W     5
`define QFB_I_AE      0
`define QFB_I_FULL    1
`define QFB_I_VALID   2
`define QFB_I_WR_REF  3
`define QFB_I_RD_REF  4

`endif

// ### shared/qfb_pkg.sv
package qfb_pkg;

`include "qfb_consts.svh"

    // ==========================================
    // bus width set-ups
    typedef enum logic [2:0] {
        QFB_M36_36,
        QFB_M36_18,
        QFB_M36_9,
        QFB_M18_36,
        QFB_M9_36
    } qfb_mode_t;

    // ==========================================
    // port carriers
    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } qfb_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } qfb_apb_rsp_t;

    typedef struct packed {
        logic [`QFB_QA_W-1:0] sel_bus;
        logic                 sel_en;
        logic                 xfer_en;
    } qfb_port_t;

    // ==========================================
    // whole block state
    typedef struct packed {
        logic [`QFB_NQ-1:0][`QFB_CNT_W-1:0] cnt;
        logic [`QFB_NQ-1:0]                 ae_s1;
        logic [`QFB_NQ-1:0]                 ne_d;
        logic [`QFB_NQ-1:0]                 pae_bus;
        logic [`QFB_QA_W-1:0]               rq;
        logic [`QFB_QA_W-1:0]               rq_pend;
        logic                               sw_pend;
        logic [`QFB_QA_W-1:0]               wq;
        logic                               pae_n;
        logic                               ov_n;
        logic                               ff_n;
        qfb_mode_t                          mode;
        logic                               pkt;
        logic [`QFB_VAL_W-1:0]              depth;
        logic [`QFB_NQ-1:0][`QFB_VAL_W-1:0] off;
        logic [`QFB_IRQ_W-1:0]              ists;
        logic [`QFB_IRQ_W-1:0]              imask;
        logic [31:0]                        prdata;
    } qfb_state_t;

endpackage

// ### src/qfb_flags.sv
`timescale 1ns/1ps
`include "qfb_consts.svh"

module qfb_flags
    import qfb_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire qfb_apb_req_t         apb_req,
    output      qfb_apb_rsp_t         apb_rsp,
    input  wire qfb_port_t            rd_port,
    input  wire qfb_port_t            wr_port,
    input  wire logic                 default_offset_select,
    output      logic                 active_almost_empty_n,
    output      logic [`QFB_NQ-1:0]   per_queue_almost_empty_bus,
    output      logic                 output_valid_n,
    output      logic                 queue_full_n,
    output      logic                 irq
);

    // ==========================================
    // state and per-queue terms
    qfb_state_t q;
    qfb_state_t s;

    logic [`QFB_UNIT_W-1:0]             iu;
    logic [`QFB_UNIT_W-1:0]             ou;
    logic [`QFB_NQ-1:0][`QFB_CNT_W-1:0] cnt_nxt;
    logic [`QFB_NQ-1:0][`QFB_CNT_W-1:0] lim;
    logic [`QFB_NQ-1:0]                 ne;
    logic [`QFB_NQ-1:0]                 ne_nxt;
    logic [`QFB_NQ-1:0]                 ae_now;
    logic [`QFB_NQ-1:0]                 full_now;
    logic [`QFB_NQ-1:0]                 full_nxt;
    logic [`QFB_NQ-1:0]                 wr_hit;
    logic [`QFB_NQ-1:0]                 rd_hit;
    logic                               setup;
    logic                               access;
    logic                               mapped;
    logic [31:0]                        rd_mux;
    logic [`QFB_IRQ_W-1:0]              ev;

    // units of nine bits moved per write and per read
    always_comb
    begin
        unique case (q.mode)
            QFB_M36_18: begin iu = `QFB_UNIT_36; ou = `QFB_UNIT_18; end
            QFB_M36_9:  begin iu = `QFB_UNIT_36; ou = `QFB_UNIT_9;  end
            QFB_M18_36: begin iu = `QFB_UNIT_18; ou = `QFB_UNIT_36; end
            QFB_M9_36:  begin iu = `QFB_UNIT_9;  ou = `QFB_UNIT_36; end
            default:    begin iu = `QFB_UNIT_36; ou = `QFB_UNIT_36; end
        endcase
    end

    // per-queue counters and status, all queues live at once
    for (genvar i = 0; i < `QFB_NQ; i++)
    begin : g_q
        logic shared;
        logic [`QFB_CNT_W-1:0] add;
        logic [`QFB_CNT_W-1:0] sub;
        // output register adds one word of room only for 36-bit output when the read and write queues are the same
        assign shared = (q.rq == `QFB_QA_W'(i)) && (q.wq == `QFB_QA_W'(i));
        // one spare bit keeps 4 x (depth + 1) from wrapping at the largest depth
        assign lim[i] = (`QFB_CNT_W'(q.depth) + ((shared && ou == `QFB_UNIT_36)
                         ? `QFB_CNT_W'(1) : `QFB_CNT_W'(0))) << 2;
        assign full_now[i] = q.cnt[i] >= lim[i];
        assign ne[i]       = q.cnt[i] >= `QFB_CNT_W'(ou);
        assign wr_hit[i]   = wr_port.xfer_en && q.wq == `QFB_QA_W'(i) && !full_now[i];
        assign rd_hit[i]   = rd_port.xfer_en && q.rq == `QFB_QA_W'(i) && ne[i];
        assign add         = wr_hit[i] ? `QFB_CNT_W'(iu) : `QFB_CNT_W'(0);
        assign sub         = rd_hit[i] ? `QFB_CNT_W'(ou) : `QFB_CNT_W'(0);
        assign cnt_nxt[i]  = q.cnt[i] + add - sub;
        assign ne_nxt[i]   = cnt_nxt[i] >= `QFB_CNT_W'(ou);
        assign full_nxt[i] = cnt_nxt[i] >= lim[i];
        // offset counted in output words
        assign ae_now[i]   = q.cnt[i] <= `QFB_CNT_W'(q.off[i]) * `QFB_CNT_W'(ou);
    end

    // ==========================================
    // apb decode and read mux
    assign setup  = apb_req.psel && !apb_req.penable;
    assign access = apb_req.psel && apb_req.penable;

    always_comb
    begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        if (apb_req.paddr[7:4] == `QFB_A_OFF_HI)
            rd_mux[`QFB_VAL_W-1:0] = q.off[apb_req.paddr[3:2]];
        else if (apb_req.paddr[7:4] == `QFB_A_CNT_HI)
            rd_mux[`QFB_CNT_W-1:0] = q.cnt[apb_req.paddr[3:2]];
        else
        begin
            unique case (apb_req.paddr)
                `QFB_A_CTRL:  rd_mux[3:0] = {q.pkt, q.mode};
                `QFB_A_FLAGS: rd_mux[13:0] = {q.sw_pend, q.rq_pend, q.rq, q.wq, q.pae_bus,
                                              q.ov_n, q.ff_n, q.pae_n};
                `QFB_A_ISTS:  rd_mux[`QFB_IRQ_W-1:0] = q.ists;
                `QFB_A_IMASK: rd_mux[`QFB_IRQ_W-1:0] = q.imask;
                `QFB_A_DEPTH: rd_mux[`QFB_VAL_W-1:0] = q.depth;
                default:      mapped = 1'b0;
            endcase
        end
        if (apb_req.paddr[1:0] != 2'h0)
            mapped = 1'b0;
    end

    assign apb_rsp.prdata  = q.prdata;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = access && !mapped;

    // ==========================================
    // next state
    always_comb
    begin
        s = q;
        s.cnt   = cnt_nxt;
        s.ae_s1 = ae_now;
        s.ne_d  = ne;
        for (int i = 0; i < `QFB_NQ; i++)
            s.pae_bus[i] = !(ae_now[i] && q.ae_s1[i]);

        // read queue switch takes two edges
        if (q.sw_pend)
            s.rq = q.rq_pend;
        s.sw_pend = rd_port.sel_en;
        if (rd_port.sel_en)
            s.rq_pend = rd_port.sel_bus;
        if (wr_port.sel_en)
            s.wq = wr_port.sel_bus;

        // active flags; almost-empty falls via second stage, rises on first; output-valid falls on first, second in packet mode; full follows the next count
        s.pae_n = !(ae_now[q.rq] && q.ae_s1[q.rq]);
        s.ov_n  = !(ne_nxt[q.rq] && ne[q.rq]
                    && (!q.pkt || q.ne_d[q.rq]));
        s.ff_n  = !full_nxt[q.wq];

        // events for interrupt status
        ev = '0;
        ev[`QFB_I_AE]     = q.pae_n && !s.pae_n;
        ev[`QFB_I_FULL]   = q.ff_n && !s.ff_n;
        ev[`QFB_I_VALID]  = q.ov_n && !s.ov_n;
        ev[`QFB_I_WR_REF] = wr_port.xfer_en && full_now[q.wq];
        ev[`QFB_I_RD_REF] = rd_port.xfer_en && !ne[q.rq];

        // register writes at access edge
        if (access && apb_req.pwrite && mapped)
        begin
            if (apb_req.paddr[7:4] == `QFB_A_OFF_HI)
                s.off[apb_req.paddr[3:2]] = (apb_req.pwdata[`QFB_VAL_W-1:0] > q.depth)
                    ? q.depth : apb_req.pwdata[`QFB_VAL_W-1:0];
            else if (apb_req.paddr == `QFB_A_CTRL)
            begin
                if (apb_req.pwdata[2:0] <= 3'(QFB_M9_36))
                    s.mode = qfb_mode_t'(apb_req.pwdata[2:0]);
                s.pkt = apb_req.pwdata[3] && (s.mode == QFB_M36_36);
            end
            else if (apb_req.paddr == `QFB_A_IMASK)
                s.imask = apb_req.pwdata[`QFB_IRQ_W-1:0];
            else if (apb_req.paddr == `QFB_A_DEPTH)
                s.depth = apb_req.pwdata[`QFB_VAL_W-1:0];
        end

        // a smaller depth pulls every offset down with it
        for (int i = 0; i < `QFB_NQ; i++)
            if (s.off[i] > s.depth)
                s.off[i] = s.depth;

        // read clears only the bits it returned; later events survive
        if (access && !apb_req.pwrite && apb_req.paddr == `QFB_A_ISTS)
            s.ists = (q.ists & ~q.prdata[`QFB_IRQ_W-1:0]) | ev;
        else
            s.ists = q.ists | ev;

        // unmapped or misaligned reads return zero
        if (setup)
            s.prdata = (apb_req.pwrite || !mapped) ? 32'h0000_0000 : rd_mux;

        // synchronous reset, strap taken while reset is held
        if (!rst_n)
        begin
            s         = '0;
            s.ae_s1   = '1;
            s.ov_n    = 1'b1;
            s.ff_n    = 1'b1;
            s.mode    = QFB_M36_36;
            s.depth   = `QFB_DEPTH_RST;
            for (int i = 0; i < `QFB_NQ; i++)
                s.off[i] = default_offset_select ? `QFB_OFF_HI : `QFB_OFF_LO;
        end
    end

    // state register
    always_ff @(posedge mclk)
    begin
        q <= s;
    end

    // ==========================================
    // outputs
    assign active_almost_empty_n      = q.pae_n;
    assign per_queue_almost_empty_bus = q.pae_bus;
    assign output_valid_n             = q.ov_n;
    assign queue_full_n               = q.ff_n;
    assign irq                        = |(q.ists & q.imask);

    // ==========================================
    // assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic ae_act;
    logic ne_act;
    assign ae_act = ae_now[q.rq];
    assign ne_act = ne[q.rq];

    active_bus_match_a: assert property (
        $stable(q.rq) |-> active_almost_empty_n == per_queue_almost_empty_bus[q.rq])
        else $error("active almost-empty differs from bus bit");

    default_offset_a: assert property (
        $rose(rst_n) |-> q.off[0] == ($past(default_offset_select) ? `QFB_OFF_HI : `QFB_OFF_LO))
        else $error("default offset wrong after reset");

    switch_delay_a: assert property (
        rd_port.sel_en ##1 !rd_port.sel_en |-> q.rq == $past(q.rq) ##1
        q.rq == $past(rd_port.sel_bus, 2))
        else $error("read queue switch not on second edge");

    pae_fall_two_a: assert property (
        ($rose(ae_act) && $stable(q.rq)) ##1 (ae_act && $stable(q.rq)) [*2]
        |-> !active_almost_empty_n && $past(active_almost_empty_n))
        else $error("almost-empty did not fall two cycles after read");

    pae_rise_one_a: assert property (
        $fell(ae_act) && $stable(q.rq) |=> active_almost_empty_n)
        else $error("almost-empty did not rise one cycle after write");

    ov_normal_a: assert property (
        $rose(ne_act) && !q.pkt && $stable(q.rq) && ne_nxt[q.rq] |=> !output_valid_n)
        else $error("output-valid late in normal mode");

    ov_packet_a: assert property (
        ($rose(ne_act) && q.pkt && $stable(q.rq) && ne_nxt[q.rq])
        ##1 (ne_nxt[q.rq] && $stable(q.rq) && $stable(q.pkt))
        |-> output_valid_n ##1 !output_valid_n)
        else $error("output-valid timing wrong in packet mode");

    full_limit_a: assert property (
        $stable(q.wq) && $stable(q.rq) && $stable(q.mode) && $stable(q.depth)
        |-> !queue_full_n == (q.cnt[q.wq] >= lim[q.wq]))
        else $error("full flag disagrees with queue limit");

    for (genvar i = 0; i < `QFB_NQ; i++)
    begin : g_chk
        off_range_a: assert property (
            q.off[i] <= q.depth || $changed(q.depth))
            else $error("offset above queue depth");
        bus_write_rise_a: assert property (
            $fell(ae_now[i]) |=> per_queue_almost_empty_bus[i])
            else $error("bus bit did not rise after write");
    end

    switch_c: cover property (rd_port.sel_en ##2 $changed(active_almost_empty_n));
    packet_c: cover property (q.pkt && $fell(output_valid_n));
    full_c:   cover property ($fell(queue_full_n) && q.mode == QFB_M9_36);
    irq_c:    cover property ($rose(irq));

endmodule

// ### test/qfb_ctl_model.sv
`timescale 1ns/1ps

// ==========================================
// system controller model on the read and write ports
module qfb_ctl_model
    import qfb_pkg::*;
(
    input  wire logic      mclk,
    output wire qfb_port_t rd_port,
    output wire qfb_port_t wr_port
);
    qfb_port_t [1:0] pp;   // index 0 read port, 1 write port

    // both ports idle from time zero
    initial
    begin
        pp = '0;
    end
    assign rd_port = pp[0];
    assign wr_port = pp[1];

    // queue number presented with enable for one edge
    task sel(input logic w, input logic [1:0] q);
        begin
            @(posedge mclk);
            pp[w].sel_bus <= q;
            pp[w].sel_en  <= 1'b1;
            @(posedge mclk);
            pp[w].sel_en  <= 1'b0;
        end
    endtask

    // strobe held high for n edges, one word each
    task xfer(input logic w, input int n);
        begin
            @(posedge mclk);
            pp[w].xfer_en <= 1'b1;
            repeat (n) @(posedge mclk);
            pp[w].xfer_en <= 1'b0;
        end
    endtask
endmodule

// ### test/queue_flag_boundary_logic_bench.sv
`timescale 1ns/1ps
`include "qfb_consts.svh"

module queue_flag_boundary_logic_bench
    import qfb_pkg::*;
;
    logic               mclk;
    logic               rst_n;
    logic               dfs;
    qfb_apb_req_t       req;
    qfb_apb_rsp_t       rsp;
    qfb_port_t          rdp;
    qfb_port_t          wrp;
    logic               ae_n;
    logic [`QFB_NQ-1:0] ae_bus;
    logic               ov_n;
    logic               ff_n;
    logic               irq;
    logic [31:0]        rdat;
    logic               serr;
    int                 n_fail;
    int                 num_checks;
    logic [2:0]         md [8] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4};
    logic               sh [8] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    int                 nw [8] = '{3, 2, 2, 2, 6, 4, 12, 8};

    qfb_flags i_dut (
        .mclk                       (mclk),
        .rst_n                      (rst_n),
        .apb_req                    (req),
        .apb_rsp                    (rsp),
        .rd_port                    (rdp),
        .wr_port                    (wrp),
        .default_offset_select      (dfs),
        .active_almost_empty_n      (ae_n),
        .per_queue_almost_empty_bus (ae_bus),
        .output_valid_n             (ov_n),
        .queue_full_n               (ff_n),
        .irq                        (irq)
    );

    qfb_ctl_model i_ctl (
        .mclk    (mclk),
        .rd_port (rdp),
        .wr_port (wrp)
    );

    // ==========================================
    // clock and watchdog
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    initial
    begin
        repeat (6000) @(posedge mclk);
        n_fail++;
        complete_run();
    end

    // ==========================================
    // shared tasks
    task complete_run();
        begin
            $display("checks %0d mismatches %0d", num_checks, n_fail);
            if (n_fail == 0 && num_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            num_checks++;
            if (got !== exp)
            begin
                n_fail++;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // apb transfer, waits on pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        begin
            t = 0;
            @(posedge mclk);
            req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
            @(posedge mclk);
            req.penable <= 1'b1;
            @(posedge mclk);
            while (rsp.pready !== 1'b1 && t < 100)
            begin
                t++;
                @(posedge mclk);
            end
            rdat = rsp.prdata;
            serr = rsp.pslverr;
            req.psel    <= 1'b0;
            req.penable <= 1'b0;
        end
    endtask

    task do_reset(input logic v);
        begin
            rst_n <= 1'b0;
            dfs   <= v;
            repeat (5) @(posedge mclk);
            rst_n <= 1'b1;
            @(posedge mclk);
        end
    endtask

    // settle after an edge
    task step();
        begin
            @(posedge mclk);
            #1;
        end
    endtask

    // ==========================================
    // main sequence
    initial
    begin
        n_fail = 0;
        num_checks = 0;
        req = '0;
        rst_n = 1'b0;
        dfs = 1'b0;
        do_reset(1'b1);
        apb(1'b0, 8'h28, 32'h0);
        chk(rdat, 32'h0000_0080);
        do_reset(1'b0);
        #1 chk({ae_n, ae_bus, ov_n, ff_n, irq}, 8'h06);
        apb(1'b0, 8'h20, 32'h0);
        chk(rdat, 32'h0000_0008);
        apb(1'b0, 8'h40, 32'h0);
        chk(serr, 1'b1);
        chk(rdat, 32'h0000_0000);
        apb(1'b1, `QFB_A_DEPTH, 32'h0000_0004);
        apb(1'b1, 8'h20, 32'h0000_0001);
        apb(1'b1, 8'h24, 32'h0000_0000);
        apb(1'b1, `QFB_A_IMASK, 32'h0000_0002);
        // first word, then almost-empty boundary on queue 0
        i_ctl.xfer(1'b1, 1);
        #1 chk(ov_n, 1'b1);
        step();
        chk(ov_n, 1'b0);
        i_ctl.xfer(1'b1, 1);
        #1 chk(ae_n, 1'b0);
        step();
        chk({ae_n, ae_bus[0]}, 2'h3);
        // fill to full, shared queue
        i_ctl.xfer(1'b1, 2);
        #1 chk(ff_n, 1'b1);
        i_ctl.xfer(1'b1, 1);
        #1 chk(ff_n, 1'b0);
        step();
        step();
        chk(irq, 1'b1);
        apb(1'b0, `QFB_A_ISTS, 32'h0);
        chk(rdat[`QFB_I_FULL], 1'b1);
        step();
        chk(irq, 1'b0);
        // reads down to the boundary
        i_ctl.xfer(1'b0, 3);
        #1 chk({ae_n, ff_n}, 2'h3);
        i_ctl.xfer(1'b0, 1);
        #1 chk(ae_n, 1'b1);
        step();
        chk(ae_n, 1'b1);
        step();
        chk(ae_n, 1'b0);
        // unselected queue 1 updates, then read switch
        i_ctl.sel(1'b1, 2'h1);
        i_ctl.xfer(1'b1, 1);
        step();
        step();
        chk({ae_n, ae_bus[1]}, 2'h1);
        i_ctl.sel(1'b0, 2'h1);
        #1 chk(ae_n, 1'b0);
        step();
        chk(ae_n, 1'b0);
        step();
        chk(ae_n, 1'b1);
        // packet mode adds one edge to output-valid
        do_reset(1'b0);
        apb(1'b1, `QFB_A_CTRL, 32'h0000_0008);
        i_ctl.xfer(1'b1, 1);
        step();
        chk(ov_n, 1'b1);
        step();
        chk(ov_n, 1'b0);
        // full boundary per bus set-up, depth 2
        for (int i = 0; i < 8; i++)
        begin
            do_reset(1'b0);
            apb(1'b1, `QFB_A_DEPTH, 32'h0000_0002);
            apb(1'b1, `QFB_A_CTRL, {29'h0, md[i]});
            if (!sh[i])
                i_ctl.sel(1'b1, 2'h1);
            i_ctl.xfer(1'b1, nw[i] - 1);
            #1 chk(ff_n, 1'b1);
            i_ctl.xfer(1'b1, 1);
            #1 chk(ff_n, 1'b0);
            step();
            chk(ov_n, !sh[i]);
        end
        complete_run();
    end
endmodule
